/* File: core/burst_sram_pkg.sv */
// shared constants and types for the pipelined burst sram control block
package burst_sram_pkg;

	// ------------------------------------------------------------
	// array geometry
	// ------------------------------------------------------------
	localparam int ADDR_W    = 17;
	localparam int DATA_W    = 32;
	localparam int LANES     = 4;
	localparam int MEM_DEPTH = 131072;

	// ------------------------------------------------------------
	// register map (byte addresses on the axi4-lite port)
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] STATUS_OFS  = 8'h04;
	localparam logic [7:0] ACC_ADR_OFS = 8'h08;

	localparam int CTRL_SLEEP_BIT    = 0;
	localparam int CTRL_OUTBLOCK_BIT = 1;
	localparam int ST_ASLEEP_BIT     = 0;
	localparam int ST_ACTIVE_BIT     = 1;
	localparam int ST_INTERLEAVE_BIT = 2;
	localparam int ST_FIRST_BIT      = 3;
	localparam int ST_CNT_LSB        = 4;

	localparam logic [1:0] CTRL_RST  = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLV  = 2'h2;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam logic [1:0] SLEEP_CYCLES = 2'h2;
	localparam logic [1:0] STRAP_WAIT   = 2'h3;

	// ------------------------------------------------------------
	// pin bundle, sampled through the synchroniser as one word
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic              first_chip_select_n;
		logic              second_chip_select;
		logic              third_chip_select_n;
		logic              cpu_addr_strobe_n;
		logic              ctrl_addr_strobe_n;
		logic              burst_step_n;
		logic              global_write_n;
		logic              byte_write_gate_n;
		logic [LANES-1:0]  byte_lane_select_n;
		logic              output_enable_n;
		logic              sleep_request;
		logic              burst_order;
	} pins_t;

	localparam int PINS_W = $bits(pins_t);

	// inactive levels; sleep reads low and the strap reads high like the pad pulls
	localparam pins_t PINS_RST = '{
		addr: '0, dq: '0,
		first_chip_select_n: 1'b1, second_chip_select: 1'b0,
		third_chip_select_n: 1'b1, cpu_addr_strobe_n: 1'b1,
		ctrl_addr_strobe_n: 1'b1, burst_step_n: 1'b1,
		global_write_n: 1'b1, byte_write_gate_n: 1'b1,
		byte_lane_select_n: 4'hf, output_enable_n: 1'b1,
		sleep_request: 1'b0, burst_order: 1'b1
	};

endpackage

/* File: core/pin_sync.sv */
// two-stage synchroniser for a bundle of pin inputs
module pin_sync
	import burst_sram_pkg::*;
#(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	// ------------------------------------------------------------
	// per-bit double flop; stage one feeds only stage two
	// ------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			logic meta_q;
			logic hold_q;
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					meta_q <= RST_VAL[b];
					hold_q <= RST_VAL[b];
				end else begin
					meta_q <= i_async[b];
					hold_q <= meta_q;
				end
			end
			assign o_sync[b] = hold_q;
		end
	endgenerate

endmodule

/* File: core/burst_counter.sv */
// two-bit wraparound burst counter, linear or interleaved
module burst_counter
	import burst_sram_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_load,
	input  wire logic [1:0] i_start,
	input  wire logic       i_step,
	input  wire logic       i_interleave,
	output logic      [1:0] o_low,
	output logic      [1:0] o_cnt
);

	// ------------------------------------------------------------
	// start point and step count
	// ------------------------------------------------------------
	logic [1:0] start_q;
	logic [1:0] steps_q;
	logic [1:0] steps_inc;
	logic [1:0] steps_use;
	logic [1:0] cnt_q;

	assign steps_inc = steps_q + 2'h1;
	assign steps_use = i_step ? steps_inc : steps_q;
	// interleaved: start xor step, linear: start plus step, wrap in two bits
	assign o_low = i_load ? i_start :
		(i_interleave ? (start_q ^ steps_use) : (start_q + steps_use));
	assign o_cnt = cnt_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			start_q <= 2'h0;
			steps_q <= 2'h0;
			cnt_q   <= 2'h0;
		end else begin
			if (i_load) begin
				start_q <= i_start;
				steps_q <= 2'h0;
			end else if (i_step) begin
				steps_q <= steps_inc;
			end
			cnt_q <= o_low;
		end
	end

endmodule

/* File: core/burst_sram_ctl.sv */
// top of the pipelined burst sram control block with axi4-lite registers
// What this block does
// - select needs all three chip enables active
// - output enable low drives the data lines
// - output enable high floats the data lines
// - first read after deselect keeps lines floating
// - burst step low advances the burst address
// - processor strobe captures the address
// - controller strobe captures the address
// - a capture while selected loads low bits into counter
// - both strobes: processor strobe wins
// - processor strobe ignored when first enable high
// - sleep request enters low power, keeps contents
// - sleep request low or open; reads inactive
// - write data registered at clock edge
// - read data one pipeline stage after address
// - strap low selects linear ordering
// - strap high or open selects interleaved
// - interleaved: start xor step count
// - linear: previous plus one, wrapping
// - global write writes all four lanes
// - detected write floats the data lines
module burst_sram_ctl
	import burst_sram_pkg::*;
(
	input  wire logic              I_REF_CLK,
	input  wire logic              I_SYS_RST,
	input  wire logic [ADDR_W-1:0] I_ADDR,
	input  wire logic              I_FIRST_CHIP_SELECT_N,
	input  wire logic              I_SECOND_CHIP_SELECT,
	input  wire logic              I_THIRD_CHIP_SELECT_N,
	input  wire logic              I_CPU_ADDR_STROBE_N,
	input  wire logic              I_CTRL_ADDR_STROBE_N,
	input  wire logic              I_BURST_STEP_N,
	input  wire logic              I_GLOBAL_WRITE_N,
	input  wire logic              I_BYTE_WRITE_GATE_N,
	input  wire logic [LANES-1:0]  I_BYTE_LANE_SELECT_N,
	input  wire logic              I_OUTPUT_ENABLE_N,
	input  wire logic              I_SLEEP_REQUEST,
	input  wire logic              I_BURST_ORDER,
	input  wire logic [DATA_W-1:0] I_DQ,
	output logic      [DATA_W-1:0] O_DQ,
	output logic                   O_DQ_OE,
	output logic                   O_SLEEPING,
	input  wire logic [7:0]        I_AXI_AWADDR,
	input  wire logic              I_AXI_AWVALID,
	output logic                   O_AXI_AWREADY,
	input  wire logic [31:0]       I_AXI_WDATA,
	input  wire logic [3:0]        I_AXI_WSTRB,
	input  wire logic              I_AXI_WVALID,
	output logic                   O_AXI_WREADY,
	output logic      [1:0]        O_AXI_BRESP,
	output logic                   O_AXI_BVALID,
	input  wire logic              I_AXI_BREADY,
	input  wire logic [7:0]        I_AXI_ARADDR,
	input  wire logic              I_AXI_ARVALID,
	output logic                   O_AXI_ARREADY,
	output logic      [31:0]       O_AXI_RDATA,
	output logic      [1:0]        O_AXI_RRESP,
	output logic                   O_AXI_RVALID,
	input  wire logic              I_AXI_RREADY
);

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	pins_t pins_raw;
	pins_t s;
	logic [PINS_W-1:0] s_vec;

	assign pins_raw = '{
		addr: I_ADDR, dq: I_DQ,
		first_chip_select_n: I_FIRST_CHIP_SELECT_N,
		second_chip_select: I_SECOND_CHIP_SELECT,
		third_chip_select_n: I_THIRD_CHIP_SELECT_N,
		cpu_addr_strobe_n: I_CPU_ADDR_STROBE_N,
		ctrl_addr_strobe_n: I_CTRL_ADDR_STROBE_N,
		burst_step_n: I_BURST_STEP_N,
		global_write_n: I_GLOBAL_WRITE_N,
		byte_write_gate_n: I_BYTE_WRITE_GATE_N,
		byte_lane_select_n: I_BYTE_LANE_SELECT_N,
		output_enable_n: I_OUTPUT_ENABLE_N,
		sleep_request: I_SLEEP_REQUEST,
		burst_order: I_BURST_ORDER
	};

	// every pin crosses two flops; the async enable is therefore seen late
	pin_sync #(
		.WIDTH   (PINS_W),
		.RST_VAL (PINS_RST)
	) u_sync (
		.i_clk   (I_REF_CLK),
		.i_rst   (I_SYS_RST),
		.i_async (pins_raw),
		.o_sync  (s_vec)
	);
	assign s = pins_t'(s_vec);

	// ------------------------------------------------------------
	// strap capture after reset release
	// ------------------------------------------------------------
	logic [1:0] strap_cnt_q;
	logic       interleave_q;

	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			strap_cnt_q  <= 2'h0;
			interleave_q <= 1'b1;
		end else if (strap_cnt_q != STRAP_WAIT) begin
			strap_cnt_q  <= strap_cnt_q + 2'h1;
			// taken on the first three cycles after reset; the strap is assumed static afterwards
			interleave_q <= s.burst_order;
		end
	end

	// ------------------------------------------------------------
	// sleep control
	// ------------------------------------------------------------
	logic [1:0] ctrl_q;
	logic [1:0] doze_q;
	logic       asleep_q;
	logic       sleep_want;

	// pad pull-down and reset value make an open pin read inactive
	assign sleep_want = s.sleep_request | ctrl_q[CTRL_SLEEP_BIT];

	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			doze_q   <= 2'h0;
			asleep_q <= 1'b0;
		end else if (sleep_want != asleep_q) begin
			if (doze_q == SLEEP_CYCLES - 2'h1) begin
				doze_q   <= 2'h0;
				asleep_q <= sleep_want;
			end else begin
				doze_q <= doze_q + 2'h1;
			end
		end else begin
			doze_q <= 2'h0;
		end
	end

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	logic             active_q;
	logic [ADDR_W-3:0] hi_q;
	logic             selected;
	logic             cpu_take;
	logic             ctrl_take;
	logic             capture;
	logic             start;
	logic             write_req;
	logic [LANES-1:0] lanes;
	logic             cont;
	logic             do_write;
	logic             do_read;
	logic             step;
	logic [1:0]       low;
	logic [1:0]       cnt;
	logic [ADDR_W-3:0] hi_use;

	assign selected  = ~s.first_chip_select_n & s.second_chip_select
		& ~s.third_chip_select_n;
	assign cpu_take  = ~s.cpu_addr_strobe_n & ~s.first_chip_select_n;
	assign ctrl_take = ~s.ctrl_addr_strobe_n & ~cpu_take;
	assign capture   = (cpu_take | ctrl_take) & ~asleep_q;
	assign start     = capture & selected;
	assign lanes     = ~s.global_write_n ? {LANES{1'b1}} :
		(~s.byte_write_gate_n ? ~s.byte_lane_select_n : {LANES{1'b0}});
	assign write_req = |lanes;
	assign cont      = active_q & ~capture & ~asleep_q;
	// processor-strobe starts ignore write controls on their first cycle
	assign do_write  = (start & ctrl_take & write_req) | (cont & write_req);
	assign do_read   = (start & ~do_write) | (cont & ~write_req);
	assign step      = cont & ~s.burst_step_n;
	assign hi_use    = start ? s.addr[ADDR_W-1:2] : hi_q;

	burst_counter u_burst (
		.i_clk        (I_REF_CLK),
		.i_rst        (I_SYS_RST),
		.i_load       (start),
		.i_start      (s.addr[1:0]),
		.i_step       (step),
		.i_interleave (interleave_q),
		.o_low        (low),
		.o_cnt        (cnt)
	);

	// ------------------------------------------------------------
	// address stage
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] acc_addr_q;
	logic [LANES-1:0]  acc_lanes_q;
	logic              acc_write_q;
	logic              acc_read_q;
	logic              acc_first_q;
	logic [DATA_W-1:0] din_q;

	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			active_q    <= 1'b0;
			hi_q        <= '0;
			acc_addr_q  <= '0;
			acc_lanes_q <= '0;
			acc_write_q <= 1'b0;
			acc_read_q  <= 1'b0;
			acc_first_q <= 1'b0;
			din_q       <= '0;
		end else begin
			if (asleep_q | (capture & ~selected)) begin
				active_q <= 1'b0;
			end else if (start) begin
				active_q <= 1'b1;
				hi_q     <= s.addr[ADDR_W-1:2];
			end
			acc_addr_q  <= {hi_use, low};
			acc_lanes_q <= lanes;
			acc_write_q <= do_write;
			acc_read_q  <= do_read;
			acc_first_q <= start & ~active_q;
			din_q       <= s.dq;
		end
	end

	// ------------------------------------------------------------
	// array and output stage
	// ------------------------------------------------------------
	logic [DATA_W-1:0] mem_rd;
	logic [DATA_W-1:0] dout_q;
	logic              oe_q;
	logic              oe_d;

	genvar ln;
	generate
		for (ln = 0; ln < LANES; ln++) begin : g_lane
			logic [7:0] lane_mem [MEM_DEPTH];
			always_ff @(posedge I_REF_CLK) begin
				if (acc_write_q & acc_lanes_q[ln]) begin
					lane_mem[acc_addr_q] <= din_q[ln*8 +: 8];
				end
			end
			assign mem_rd[ln*8 +: 8] = lane_mem[acc_addr_q];
		end
	endgenerate

	// drive only for an unmasked read outside writes
	assign oe_d = acc_read_q & ~acc_first_q & ~s.output_enable_n
		& ~write_req & ~acc_write_q & active_q
		& ~asleep_q & ~ctrl_q[CTRL_OUTBLOCK_BIT];

	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			dout_q <= '0;
			oe_q   <= 1'b0;
		end else begin
			if (acc_read_q) begin
				dout_q <= mem_rd;
			end
			oe_q <= oe_d;
		end
	end

	assign O_DQ       = dout_q;
	assign O_DQ_OE    = oe_q;
	assign O_SLEEPING = asleep_q;

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	logic       awready_q;
	logic       wready_q;
	logic       aw_have_q;
	logic       w_have_q;
	logic [7:0] awaddr_q;
	logic [1:0] wdata_q;
	logic       wstrb0_q;
	logic       bvalid_q;
	logic [1:0] bresp_q;
	logic       aw_fire;
	logic       w_fire;
	logic       aw_now;
	logic       w_now;
	logic       wr_go;
	logic [7:0] wr_addr;
	logic [1:0] wr_data;
	logic       wr_strb;

	assign aw_fire = I_AXI_AWVALID & awready_q;
	assign w_fire  = I_AXI_WVALID & wready_q;
	assign aw_now  = aw_have_q | aw_fire;
	assign w_now   = w_have_q | w_fire;
	assign wr_go   = aw_now & w_now & ~bvalid_q;
	assign wr_addr = aw_have_q ? awaddr_q : I_AXI_AWADDR;
	assign wr_data = w_have_q ? wdata_q : I_AXI_WDATA[1:0];
	assign wr_strb = w_have_q ? wstrb0_q : I_AXI_WSTRB[0];

	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 2'h0;
			wstrb0_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			ctrl_q    <= CTRL_RST;
		end else begin
			if (aw_fire) begin
				awaddr_q <= I_AXI_AWADDR;
			end
			if (w_fire) begin
				wdata_q  <= I_AXI_WDATA[1:0];
				wstrb0_q <= I_AXI_WSTRB[0];
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (wr_addr == CTRL_OFS || wr_addr == STATUS_OFS
					|| wr_addr == ACC_ADR_OFS) ? RESP_OKAY : RESP_SLV;
				if (wr_addr == CTRL_OFS && wr_strb) begin
					ctrl_q <= wr_data;
				end
			end else begin
				aw_have_q <= aw_now;
				w_have_q  <= w_now;
				if (bvalid_q & I_AXI_BREADY) begin
					bvalid_q <= 1'b0;
				end
			end
			// ready drops while a word is held or the answer waits
			awready_q <= ~aw_now & ~bvalid_q & ~wr_go;
			wready_q  <= ~w_now & ~bvalid_q & ~wr_go;
		end
	end

	assign O_AXI_AWREADY = awready_q;
	assign O_AXI_WREADY  = wready_q;
	assign O_AXI_BVALID  = bvalid_q;
	assign O_AXI_BRESP   = bresp_q;

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        ar_fire;
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic        rd_hit;

	assign ar_fire     = I_AXI_ARVALID & arready_q;
	assign status_word = {26'h0, cnt, acc_first_q, interleave_q, active_q, asleep_q};
	assign rd_hit      = (I_AXI_ARADDR == CTRL_OFS) || (I_AXI_ARADDR == STATUS_OFS)
		|| (I_AXI_ARADDR == ACC_ADR_OFS);
	assign rd_word     = (I_AXI_ARADDR == CTRL_OFS)    ? {30'h0, ctrl_q} :
		(I_AXI_ARADDR == STATUS_OFS)  ? status_word :
		(I_AXI_ARADDR == ACC_ADR_OFS) ? {15'h0, acc_addr_q} : 32'h0;

	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= RESP_OKAY;
		end else if (ar_fire) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_word;
			rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLV;
		end else if (rvalid_q & I_AXI_RREADY) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end else if (~rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	assign O_AXI_ARREADY = arready_q;
	assign O_AXI_RVALID  = rvalid_q;
	assign O_AXI_RDATA   = rdata_q;
	assign O_AXI_RRESP   = rresp_q;

endmodule

/* File: tb/sram_host_model.sv */
// processor-side model driving the sram pins of the control block
module sram_host_model
	import burst_sram_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_order,
	output pins_t     o_pins
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// pin state
	// ------------------------------------------------------------
	pins_t             p       = PINS_RST;
	logic              drv_q   = 1'b0;
	logic [DATA_W-1:0] float_q = 32'h5555aaaa;
	logic              oe_n    = 1'b1;
	logic              sleep   = 1'b0;

	// released data lines must never echo the last driven word
	always @(posedge i_clk) float_q <= ~float_q;

	always_comb begin
		o_pins = p;
		o_pins.dq = drv_q ? p.dq : float_q;
		o_pins.burst_order = i_order; // only moved while in reset
	end

	// ------------------------------------------------------------
	// one command cycle, then a quiet cycle with the same chip selects
	// kinds: 0 cpu read, 1 ctrl read, 2 ctrl global write, 3 ctrl lane0 write,
	// 4 burst step, 5 deselect, 6 both strobes with write, 7 cpu with cs1 high
	// ------------------------------------------------------------
	task automatic op(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		pins_t q;
		q = PINS_RST;
		q.addr = a;
		q.dq = d;
		q.first_chip_select_n = (k == 7);
		q.second_chip_select = (k != 5);
		q.third_chip_select_n = 1'b0;
		q.cpu_addr_strobe_n = !(k == 0 || k >= 6);
		q.ctrl_addr_strobe_n = !(k inside {1, 2, 3, 5, 6});
		q.burst_step_n = (k != 4);
		q.global_write_n = !(k == 2 || k == 6);
		q.byte_write_gate_n = (k != 3);
		q.byte_lane_select_n = (k == 3) ? 4'he : 4'hf;
		q.output_enable_n = oe_n;
		q.sleep_request = sleep; // low unless the bench asks
		@(posedge i_clk);
		p <= q;
		drv_q <= (k inside {2, 3, 6});
		q.cpu_addr_strobe_n = 1'b1;
		q.ctrl_addr_strobe_n = 1'b1;
		q.burst_step_n = 1'b1;
		q.global_write_n = 1'b1;
		q.byte_write_gate_n = 1'b1;
		@(posedge i_clk);
		p <= q;
		drv_q <= 1'b0;
	endtask

	task automatic set(input logic oe, input logic slp);
		oe_n = oe;
		sleep = slp;
		@(posedge i_clk);
		p.output_enable_n <= oe;
		p.sleep_request <= slp;
	endtask
endmodule

/* File: tb/sram_ctl_checker.sv */
// concurrent checks on the ports of the burst sram control block
module sram_ctl_checker (
	input wire logic I_REF_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_SECOND_CHIP_SELECT,
	input wire logic I_CPU_ADDR_STROBE_N,
	input wire logic I_CTRL_ADDR_STROBE_N,
	input wire logic I_GLOBAL_WRITE_N,
	input wire logic I_OUTPUT_ENABLE_N,
	input wire logic I_SLEEP_REQUEST,
	input wire logic O_DQ_OE,
	input wire logic O_SLEEPING,
	input wire logic O_AXI_AWREADY,
	input wire logic O_AXI_WREADY,
	input wire logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	input wire logic O_AXI_ARREADY,
	input wire logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY
);
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_SYS_RST);

	// ------------------------------------------------------------
	// pin side; pins pass two sync flops, hence the delays
	// ------------------------------------------------------------
	oe_float_a: assert property (I_OUTPUT_ENABLE_N [*5] |-> !O_DQ_OE)
		else $error("data lines driven with output enable high");
	deselect_a: assert property (!I_CTRL_ADDR_STROBE_N && !I_SECOND_CHIP_SELECT
		|-> ##[2:5] !O_DQ_OE) else $error("data lines driven after deselect");
	wr_float_a: assert property (!I_GLOBAL_WRITE_N && !I_CTRL_ADDR_STROBE_N
		&& I_CPU_ADDR_STROBE_N |-> ##3 (!O_DQ_OE) [*2]) else $error("data driven in write");
	sleep_on_a: assert property (I_SLEEP_REQUEST [*8] |-> O_SLEEPING)
		else $error("sleep not entered");
	sleep_off_a: assert property (!I_SLEEP_REQUEST [*8] |-> !O_SLEEPING)
		else $error("sleep without request");

	// ------------------------------------------------------------
	// register port handshakes
	// ------------------------------------------------------------
	wr_busy_a: assert property (O_AXI_BVALID |-> !O_AXI_AWREADY && !O_AXI_WREADY)
		else $error("write taken while response pending");
	rd_busy_a: assert property (O_AXI_RVALID |-> !O_AXI_ARREADY)
		else $error("read taken while data pending");
	b_done_a: assert property (O_AXI_BVALID && I_AXI_BREADY |=> !O_AXI_BVALID)
		else $error("write response repeated");
	r_done_a: assert property (O_AXI_RVALID && I_AXI_RREADY |=> !O_AXI_RVALID)
		else $error("read data repeated");

	cover property ($rose(O_SLEEPING));
	cover property ($rose(O_DQ_OE));
	cover property (O_AXI_BVALID && I_AXI_BREADY);
	cover property (O_AXI_RVALID && I_AXI_RREADY);
endmodule

bind burst_sram_ctl sram_ctl_checker chk (.I_REF_CLK, .I_SYS_RST, .I_SECOND_CHIP_SELECT,
	.I_CPU_ADDR_STROBE_N, .I_CTRL_ADDR_STROBE_N, .I_GLOBAL_WRITE_N, .I_OUTPUT_ENABLE_N,
	.I_SLEEP_REQUEST, .O_DQ_OE, .O_SLEEPING, .O_AXI_AWREADY, .O_AXI_WREADY, .O_AXI_BVALID,
	.I_AXI_BREADY, .O_AXI_ARREADY, .O_AXI_RVALID, .I_AXI_RREADY);

/* File: tb/tb_pipelined_burst_sram_control.sv */
// self-checking bench for the burst sram control block
module tb_pipelined_burst_sram_control
	import burst_sram_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] BASE = 17'h1a5c4;
	logic              clk     = 1'b0;
	logic              rst     = 1'b1;
	logic              order   = 1'b1;
	logic [7:0]        awaddr  = 8'h00;
	logic [7:0]        araddr  = 8'h00;
	logic [31:0]       wdata   = 32'h0;
	logic [3:0]        wstrb   = 4'hf;
	logic              awvalid = 1'b0;
	logic              wvalid  = 1'b0;
	logic              bready  = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready  = 1'b0;
	pins_t             pins;
	logic [DATA_W-1:0] o_dq;
	logic [31:0]       rdata;
	logic [1:0]        bresp, rresp;
	logic              dq_oe, sleeping, awready, wready, bvalid, arready, rvalid;
	logic [31:0]       exp_m [4];
	int                errors   = 0;
	int                compares = 0;

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end

	always #12.5 clk = ~clk;

	sram_host_model m (.i_clk(clk), .i_order(order), .o_pins(pins));

	burst_sram_ctl dut (
		.I_REF_CLK(clk), .I_SYS_RST(rst), .I_ADDR(pins.addr),
		.I_FIRST_CHIP_SELECT_N(pins.first_chip_select_n),
		.I_SECOND_CHIP_SELECT(pins.second_chip_select),
		.I_THIRD_CHIP_SELECT_N(pins.third_chip_select_n),
		.I_CPU_ADDR_STROBE_N(pins.cpu_addr_strobe_n),
		.I_CTRL_ADDR_STROBE_N(pins.ctrl_addr_strobe_n), .I_BURST_STEP_N(pins.burst_step_n),
		.I_GLOBAL_WRITE_N(pins.global_write_n), .I_BYTE_WRITE_GATE_N(pins.byte_write_gate_n),
		.I_BYTE_LANE_SELECT_N(pins.byte_lane_select_n),
		.I_OUTPUT_ENABLE_N(pins.output_enable_n), .I_SLEEP_REQUEST(pins.sleep_request),
		.I_BURST_ORDER(pins.burst_order), .I_DQ(dq_oe && !m.drv_q ? o_dq : pins.dq), .O_DQ(o_dq),
		.O_DQ_OE(dq_oe), .O_SLEEPING(sleeping), .I_AXI_AWADDR(awaddr),
		.I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata),
		.I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
		.O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
		.I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
		.O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready));

	// ------------------------------------------------------------
	// register bus and helpers
	// ------------------------------------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// pins cross two sync flops; six edges leaves the pipe settled
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic do_reset(input logic o);
		@(posedge clk);
		rst <= 1'b1;
		order <= o;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic summarize();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axr(CTRL_OFS, d, r);
		`CHK("ctrl reset", 32'h0, d)
		axr(STATUS_OFS, d, r);
		`CHK("strap", order, d[ST_INTERLEAVE_BIT])
		axw(8'h0c, 32'h3, r);
		`CHK("unmapped wr", RESP_SLV, r)
		axr(8'h0c, d, r);
		`CHK("unmapped rd", RESP_SLV, r)
	endtask

	task automatic t_write();
		m.oe_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			exp_m[i] = 32'h5a3c9600 + 32'(i);
			m.op(2, BASE + ADDR_W'(i), exp_m[i]);
		end
		m.op(3, BASE + 17'h1, 32'hffffffc3);
		exp_m[1][7:0] = 8'hc3;
		m.oe_n = 1'b0;
		for (int i = 0; i < 4; i++) begin
			m.op(0, BASE + ADDR_W'(i), 32'h0);
			settle();
			`CHK("read data", exp_m[i], o_dq)
			`CHK("drive on", 1'b1, dq_oe)
		end
	endtask

	task automatic t_burst(input logic [1:0] s);
		logic [31:0]       d;
		logic [1:0]        r;
		logic [1:0]        nx;
		logic [ADDR_W-1:0] e;
		m.op(1, BASE + ADDR_W'(s), 32'h0);
		for (int n = 0; n < 4; n++) begin
			if (n > 0) m.op(4, ~BASE, 32'h0);
			settle();
			nx = order ? (s ^ 2'(n)) : (s + 2'(n));
			e = {BASE[ADDR_W-1:2], nx};
			axr(ACC_ADR_OFS, d, r);
			`CHK("burst addr", e, d[ADDR_W-1:0])
			`CHK("burst data", exp_m[nx], o_dq)
		end
	endtask

	task automatic t_prio();
		logic [31:0] d;
		logic [1:0]  r;
		m.op(2, BASE, exp_m[0]);
		m.op(6, BASE, 32'hdeadbeef);
		m.op(0, BASE, 32'h0);
		settle();
		`CHK("cpu wins", exp_m[0], o_dq)
		m.op(7, BASE + 17'h2, 32'h0);
		settle();
		`CHK("cs1 gate", 1'b1, dq_oe)
		axr(ACC_ADR_OFS, d, r);
		`CHK("cpu gated", BASE, d[ADDR_W-1:0])
	endtask

	task automatic t_first();
		logic [31:0] d;
		logic [1:0]  r;
		logic        seen = 1'b0;
		m.op(5, BASE, 32'h0);
		m.op(0, BASE + 17'h3, 32'h0);
		repeat (8) begin
			@(posedge clk);
			#1;
			if (!seen && o_dq === exp_m[3]) begin
				seen = 1'b1;
				`CHK("first mask", 1'b0, dq_oe)
			end
		end
		`CHK("first data", 1'b1, seen)
		m.set(1'b1, 1'b0);
		settle();
		`CHK("oe high", 1'b0, dq_oe)
		m.set(1'b0, 1'b0);
		axw(CTRL_OFS, 32'h2, r);
		settle();
		`CHK("out block", 1'b0, dq_oe)
		axr(CTRL_OFS, d, r);
		`CHK("ctrl back", 32'h2, d)
		axw(CTRL_OFS, 32'h0, r);
		settle();
		`CHK("drive back", 1'b1, dq_oe)
	endtask

	task automatic t_sleep();
		m.op(5, BASE, 32'h0);
		m.set(1'b0, 1'b1);
		settle();
		`CHK("asleep", 1'b1, sleeping)
		m.set(1'b0, 1'b0);
		settle();
		`CHK("awake", 1'b0, sleeping)
		m.op(0, BASE + 17'h1, 32'h0);
		settle();
		`CHK("kept", exp_m[1], o_dq)
	endtask

	initial begin
		#500000;
		errors++;
		summarize();
	end

	initial begin
		do_reset(1'b1);
		t_regs();
		t_write();
		t_burst(2'h1);
		t_prio();
		t_first();
		t_sleep();
		do_reset(1'b0);
		t_regs();
		t_write();
		t_burst(2'h3);
		summarize();
	end
endmodule
